// file: rtl/slo_device.sv
// Device end: link output control registers and their effects.
// Assumes register port on slo_if and one 10 MHz clock.
`default_nettype none
// Functional notes
// - Second pin invert bit inverts second pin
// - First pin invert bit inverts first pin
// - Swap bit exchanges the two pins
// - Overrange to stream at 0000, pins 1111
// - Frames per multiframe is stored plus one
// - Override enable takes sync from register
// - Override value one sends K28.5 everywhere
// - Sysref policy field selects pulse handling
// - Lane code 1..13 valid, others unused
// - Code 2 needs truncate bit set
// - Software programs downconverter divider per mode
// - Serializer divider 4 for 8-4-8-10 only
// - Clock balance only for bypass 8-4-2-2
// - Lane mask powers lanes, all on reset
// - Sync invert bit flips external sync
// - Link test sequence field selects pattern
// - Ramp advances by step plus one
// - Ramp enable replaces sample data
// - Toggle alternates 0000 and FFFF
// - Function zero: pins form differential sync
module slo_device
	import slo_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Register port
	slo_if.dev bus,
	// Pins and data
	input wire logic i_first_pin,
	input wire logic i_second_pin,
	input wire logic i_sysref,
	input wire logic i_overrange,
	input wire logic [15:0] i_sample,
	input wire logic [2:0] i_gpin_func,
	// Link side outputs
	output logic [15:0] o_tx_word,
	output logic o_tx_sync_char,
	output logic [7:0] o_lane_power,
	output logic o_frame_start,
	output logic o_sysref_used,
	output logic o_ovr_in_stream,
	output logic o_ovr_on_pin,
	output logic o_lane_code_valid,
	output logic [2:0] o_link_seq
);
	typedef struct packed {
		logic [7:0] fpm, syn, arr, ddc, ser, trb, len, spol, seq, tpat, gpol, overrange_flag;
		logic [7:0] frame_cnt;
		logic [1:0] sr_seen;
		logic sr_done;
		logic [15:0] ramp;
		logic tog;
		logic [7:0] rdata;
		logic rvalid;
		logic [15:0] tx;
		logic sync_char;
		logic fstart;
		logic sr_used;
		logic ovr_s, ovr_p, code_ok;
	} slo_dev_t;
	slo_dev_t st_ff, nxt_st;
	logic first_c, second_c, sync_req, use_pulse;
	logic [15:0] data;
	// ----------------------------------------
	// Pin conditioning
	// ----------------------------------------
	slo_pin_cond u_first (
		.i_level (st_ff.gpol[BIT_PIN_SWAP] ? i_second_pin : i_first_pin),
		.i_invert (st_ff.gpol[BIT_FIRST_INV]),
		.o_level (first_c)
	);
	slo_pin_cond u_second (
		.i_level (st_ff.gpol[BIT_PIN_SWAP] ? i_first_pin : i_second_pin),
		.i_invert (st_ff.gpol[BIT_SECOND_INV]),
		.o_level (second_c)
	);
	// Sync source: differential pair or first pin alone, then inversion, then override
	always_comb
	begin
		sync_req = (i_gpin_func == GPIN_FUNC_DIFF_SYNC) ? (first_c & ~second_c) : first_c;
		sync_req = sync_req ^ st_ff.spol[BIT_SYNC_PIN_INVERT];
		if (st_ff.syn[BIT_SYNC_OVR_EN])
			sync_req = st_ff.syn[BIT_SYNC_OVR_VAL];
	end
	// Sysref acceptance per policy
	always_comb
	begin
		case (slo_sysref_t'(st_ff.syn[2:0]))
			SR_ALL: use_pulse = 1'b1;
			SR_SKIP1_ONE: use_pulse = (st_ff.sr_seen == 2'd1) && !st_ff.sr_done;
			SR_SKIP1_ALL: use_pulse = (st_ff.sr_seen >= 2'd1);
			SR_SKIP2_ONE: use_pulse = (st_ff.sr_seen == 2'd2) && !st_ff.sr_done;
			SR_SKIP2_ALL: use_pulse = (st_ff.sr_seen == 2'd2);
			default: use_pulse = 1'b0;
		endcase
	end
	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rvalid = 1'b0;
		nxt_st.sr_used = 1'b0;
		// Register writes; reads answer next cycle
		if (bus.wr)
		begin
			case (bus.addr)
				ADDR_FRAMES_PER_MF: nxt_st.fpm = bus.wdata;
				ADDR_SYNC_SYSREF: nxt_st.syn = bus.wdata;
				ADDR_LANE_ARR: nxt_st.arr = bus.wdata;
				ADDR_DDC_DIV: nxt_st.ddc = bus.wdata;
				ADDR_SER_DIV: nxt_st.ser = bus.wdata;
				ADDR_TRUNC_BAL: nxt_st.trb = bus.wdata;
				ADDR_LANE_EN: nxt_st.len = bus.wdata;
				ADDR_SYNC_POL: nxt_st.spol = bus.wdata;
				ADDR_LINK_SEQ: nxt_st.seq = bus.wdata;
				ADDR_TPORT_PAT: nxt_st.tpat = bus.wdata;
				ADDR_GPIN_POL: nxt_st.gpol = bus.wdata;
				ADDR_OVR_ROUTE: nxt_st.overrange_flag = bus.wdata;
				default: ;
			endcase
			// Policy change restarts pulse counting
			if (bus.addr == ADDR_SYNC_SYSREF)
			begin
				nxt_st.sr_seen = 2'd0;
				nxt_st.sr_done = 1'b0;
			end
		end
		if (bus.rd)
		begin
			nxt_st.rvalid = 1'b1;
			case (bus.addr)
				ADDR_FRAMES_PER_MF: nxt_st.rdata = st_ff.fpm;
				ADDR_SYNC_SYSREF: nxt_st.rdata = st_ff.syn;
				ADDR_LANE_ARR: nxt_st.rdata = st_ff.arr;
				ADDR_DDC_DIV: nxt_st.rdata = st_ff.ddc;
				ADDR_SER_DIV: nxt_st.rdata = st_ff.ser;
				ADDR_TRUNC_BAL: nxt_st.rdata = st_ff.trb;
				ADDR_LANE_EN: nxt_st.rdata = st_ff.len;
				ADDR_SYNC_POL: nxt_st.rdata = st_ff.spol;
				ADDR_LINK_SEQ: nxt_st.rdata = st_ff.seq;
				ADDR_TPORT_PAT: nxt_st.rdata = st_ff.tpat;
				ADDR_GPIN_POL: nxt_st.rdata = st_ff.gpol;
				ADDR_OVR_ROUTE: nxt_st.rdata = st_ff.overrange_flag;
				default: nxt_st.rdata = RST_ZERO;
			endcase
		end
		// Sysref pulse counting for skip policies
		if (i_sysref && !(bus.wr && bus.addr == ADDR_SYNC_SYSREF))
		begin
			if (use_pulse)
			begin
				nxt_st.sr_used = 1'b1;
				nxt_st.sr_done = 1'b1;
				nxt_st.frame_cnt = 8'h00; // Used pulse realigns multiframe
			end
			if (st_ff.sr_seen != 2'd2)
				nxt_st.sr_seen = st_ff.sr_seen + 2'd1;
		end
		// Multiframe counter wraps at stored value, giving value plus one frames
		if (!(i_sysref && use_pulse))
			nxt_st.frame_cnt = (st_ff.frame_cnt >= st_ff.fpm) ? 8'h00 : st_ff.frame_cnt + 8'h01;
		nxt_st.fstart = (nxt_st.frame_cnt == 8'h00);
		// Transport test patterns
		if (st_ff.tpat[BIT_RAMP_EN])
			nxt_st.ramp = st_ff.ramp + {12'h000, st_ff.tpat[7:4]} + 16'h0001;
		nxt_st.tog = ~st_ff.tog;
		nxt_st.sync_char = sync_req;
		nxt_st.tx = sync_req ? K28_5 : data;
		// Overrange routing and lane code check
		nxt_st.ovr_s = (st_ff.overrange_flag[7:4] == OVR_ON_LINK) && i_overrange;
		nxt_st.ovr_p = (st_ff.overrange_flag[7:4] == OVR_ON_PINS) && i_overrange;
		nxt_st.code_ok = (st_ff.arr != 8'h00) && (st_ff.arr <= LANE_ARR_MAX);
	end
	// Sample path: ramp over toggle over data, with truncation in 12-bit mode
	always_comb
	begin
		data = i_sample;
		if (st_ff.arr == LANE_ARR_12BIT && st_ff.trb[BIT_TRUNCATE])
			data = {i_sample[15:1], 1'b0};
		if (st_ff.tpat[BIT_TOGGLE_EN])
			data = st_ff.tog ? TOGGLE_HIGH : TOGGLE_LOW;
		if (st_ff.tpat[BIT_RAMP_EN])
			data = st_ff.ramp;
	end
	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st_ff <= '0;
			st_ff.len <= RST_LANE_EN;
		end
		else
			st_ff <= nxt_st;
	end
	// Outputs straight from flip-flops
	assign bus.rdata = st_ff.rdata;
	assign bus.rvalid = st_ff.rvalid;
	assign o_tx_word = st_ff.tx;
	assign o_tx_sync_char = st_ff.sync_char;
	assign o_lane_power = st_ff.len;
	assign o_frame_start = st_ff.fstart;
	assign o_sysref_used = st_ff.sr_used;
	assign o_ovr_in_stream = st_ff.ovr_s;
	assign o_ovr_on_pin = st_ff.ovr_p;
	assign o_lane_code_valid = st_ff.code_ok;
	assign o_link_seq = st_ff.seq[2:0];
endmodule
`default_nettype wire

// file: rtl/slo_pkg.sv
// Shared constants for the serial link output control block.
// Assumes a 10 MHz system clock and byte-wide register access.
`default_nettype none
package slo_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [11:0] ADDR_FRAMES_PER_MF = 12'h0020;
	localparam logic [11:0] ADDR_SYNC_SYSREF = 12'h0021;
	localparam logic [11:0] ADDR_LANE_ARR = 12'h0022;
	localparam logic [11:0] ADDR_DDC_DIV = 12'h0024;
	localparam logic [11:0] ADDR_SER_DIV = 12'h0025;
	localparam logic [11:0] ADDR_TRUNC_BAL = 12'h0027;
	localparam logic [11:0] ADDR_LANE_EN = 12'h0028;
	localparam logic [11:0] ADDR_SYNC_POL = 12'h002b;
	localparam logic [11:0] ADDR_LINK_SEQ = 12'h002d;
	localparam logic [11:0] ADDR_TPORT_PAT = 12'h002e;
	localparam logic [11:0] ADDR_GPIN_POL = 12'h0236;
	localparam logic [11:0] ADDR_OVR_ROUTE = 12'h0238;
	// Controller's own registers (byte addresses)
	localparam logic [31:0] WB_CMD = 32'h0000_0000;
	localparam logic [31:0] WB_STAT = 32'h0000_0004;
	localparam logic [31:0] WB_PINS = 32'h0000_0008;
	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int BIT_SECOND_INV = 6;
	localparam int BIT_FIRST_INV = 5;
	localparam int BIT_PIN_SWAP = 4;
	localparam int BIT_SYNC_OVR_EN = 6;
	localparam int BIT_SYNC_OVR_VAL = 5;
	localparam int BIT_SYNC_PIN_INVERT = 0;
	localparam int BIT_RAMP_EN = 2;
	localparam int BIT_TOGGLE_EN = 1;
	localparam int BIT_TRUNCATE = 5;
	localparam int BIT_CLK_BAL = 1;
	localparam logic [7:0] RST_LANE_EN = 8'hff;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [3:0] OVR_ON_LINK = 4'h0;
	localparam logic [3:0] OVR_ON_PINS = 4'hf;
	localparam logic [7:0] LANE_ARR_12BIT = 8'h02;
	localparam logic [7:0] LANE_ARR_MAX = 8'h0d;
	localparam logic [15:0] TOGGLE_LOW = 16'h0000;
	localparam logic [15:0] TOGGLE_HIGH = 16'hffff;
	localparam logic [15:0] K28_5 = 16'hbcbc;
	localparam logic [2:0] GPIN_FUNC_DIFF_SYNC = 3'h0;
	// ----------------------------------------
	// Test sequence and sysref codes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEQ_OFF = 3'd0, SEQ_D21_5 = 3'd1, SEQ_K28_5 = 3'd2, SEQ_ILA = 3'd3,
		SEQ_RANDOM = 3'd4, SEQ_SCR_JIT = 3'd5, SEQ_K28_7 = 3'd6, SEQ_SHORT = 3'd7
	} slo_seq_t;
	typedef enum logic [2:0] {
		SR_IGNORE = 3'd0, SR_ALL = 3'd1, SR_NONE = 3'd2, SR_SKIP1_ONE = 3'd3,
		SR_SKIP1_ALL = 3'd4, SR_SKIP2_ONE = 3'd5, SR_SKIP2_ALL = 3'd6
	} slo_sysref_t;
	// Controller state machine, Gray coded from CS_IDLE through CS_REQ to CS_DONE; the return to CS_IDLE flips both bits
	typedef enum logic [1:0] {
		CS_IDLE = 2'b00, CS_REQ = 2'b01, CS_DONE = 2'b11
	} slo_cstate_t;
endpackage
`default_nettype wire

// file: rtl/slo_if.sv
// Register access port between controller and device.
// Assumes both ends share one clock; a write or read takes one cycle.
`default_nettype none
interface slo_if;
	logic wr;
	logic rd;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	modport dev (input wr, input rd, input addr, input wdata, output rdata, output rvalid);
	modport ctl (output wr, output rd, output addr, output wdata, input rdata, input rvalid);
endinterface
`default_nettype wire

// file: rtl/slo_pin_cond.sv
// Conditions one general-purpose pin level: optional inversion.
// Assumes synchronous inputs.
`default_nettype none
module slo_pin_cond
	import slo_pkg::*;
(
	// Pin and control
	input wire logic i_level,
	input wire logic i_invert,
	// Conditioned level
	output logic o_level
);
	// Inversion before internal use
	assign o_level = i_level ^ i_invert;
endmodule
`default_nettype wire

// file: rtl/slo_ctrl.sv
// Controller end: Wishbone slave turning software orders into register accesses.
// Assumes a classic Wishbone master on the same clock.
`default_nettype none
module slo_ctrl
	import slo_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [31:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Device register port
	slo_if.ctl dev
);
	typedef struct packed {
		slo_cstate_t cs;
		logic [7:0] rdata;
		logic wr, rd;
		logic [11:0] addr;
		logic [7:0] wdata;
		logic [31:0] dat;
		logic ack;
	} slo_ctl_t;
	slo_ctl_t st_ff, nxt_st;
	logic req;
	// Command word: bit 31 write, bits 27:16 address, bits 7:0 data
	always_comb
	begin
		req = i_wb_cyc && i_wb_stb && !st_ff.ack;
		nxt_st = st_ff;
		nxt_st.ack = 1'b0;
		nxt_st.wr = 1'b0;
		nxt_st.rd = 1'b0;
		case (st_ff.cs)
			CS_IDLE:
				if (dev.rvalid)
					nxt_st.rdata = dev.rdata;
			CS_REQ:
				nxt_st.cs = CS_DONE;
			CS_DONE:
			begin
				if (dev.rvalid)
					nxt_st.rdata = dev.rdata;
				nxt_st.cs = CS_IDLE;
			end
			default: nxt_st.cs = CS_IDLE;
		endcase
		if (req)
		begin
			nxt_st.ack = 1'b1;
			nxt_st.dat = 32'h0000_0000;
			case (i_wb_adr)
				WB_CMD:
					if (i_wb_we && i_wb_sel == 4'hf && st_ff.cs == CS_IDLE)
					begin
						nxt_st.wr = i_wb_dat[31];
						nxt_st.rd = !i_wb_dat[31];
						nxt_st.addr = i_wb_dat[27:16];
						nxt_st.wdata = i_wb_dat[7:0];
						nxt_st.cs = CS_REQ;
					end
				WB_STAT:
					nxt_st.dat = {30'h0000_0000, st_ff.cs != CS_IDLE, 1'b0};
				WB_PINS:
					nxt_st.dat = {24'h00_0000, st_ff.rdata};
				default: ;
			endcase
		end
	end
	// State register
	always_ff @(posedge i_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end
	assign o_wb_dat = st_ff.dat;
	assign o_wb_ack = st_ff.ack;
	assign dev.wr = st_ff.wr;
	assign dev.rd = st_ff.rd;
	assign dev.addr = st_ff.addr;
	assign dev.wdata = st_ff.wdata;
endmodule
`default_nettype wire

// file: tb/slo_props.sv
// Checker for the register port and the device's link outputs.
// Assumes one clock; the bench instantiates it beside the interface.
`default_nettype none
module slo_props
	import slo_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// Register port
	input wire logic wr,
	input wire logic rd,
	input wire logic [11:0] addr,
	input wire logic [7:0] wdata,
	input wire logic rvalid,
	// Device outputs
	input wire logic [15:0] o_tx_word,
	input wire logic o_tx_sync_char,
	input wire logic [7:0] o_lane_power,
	input wire logic o_ovr_in_stream,
	input wire logic o_ovr_on_pin,
	input wire logic o_lane_code_valid,
	input wire logic [2:0] o_link_seq
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// Two edges after a write covers both a direct and a re-registered output
	chk_read_answer: assert property (rd |=> rvalid)
		else $error("read strobe not answered");
	chk_stray_answer: assert property (rvalid |-> $past(rd))
		else $error("answer without read");
	chk_sync_word: assert property (o_tx_sync_char |-> o_tx_word == K28_5)
		else $error("sync without K28.5 word");
	chk_ovr_route: assert property (wr && addr == ADDR_OVR_ROUTE && wdata[7:4] == OVR_ON_PINS |-> ##2 !o_ovr_in_stream)
		else $error("overrange left in stream");
	chk_lane_mask: assert property (wr && addr == ADDR_LANE_EN |-> ##2 o_lane_power == $past(wdata, 2))
		else $error("lane power not following mask");
	chk_link_seq: assert property (wr && addr == ADDR_LINK_SEQ |-> ##2 o_link_seq == $past(wdata[2:0], 2))
		else $error("test sequence not following field");
	chk_code_valid: assert property (wr && addr == ADDR_LANE_ARR |-> ##2 o_lane_code_valid == ($past(wdata, 2) inside {[8'h01:LANE_ARR_MAX]}))
		else $error("lane code validity wrong");
	chk_sync_forced: assert property (wr && addr == ADDR_SYNC_SYSREF && wdata[6:5] == 2'b11 |-> ##[2:3] o_tx_sync_char)
		else $error("override sync not sent");
	chk_sync_released: assert property (wr && addr == ADDR_SYNC_SYSREF && wdata[6:5] == 2'b10 |-> ##[2:3] !o_tx_sync_char)
		else $error("override release ignored");
	chk_reset_values: assert property ($rose(i_nrst) |-> o_lane_power == RST_LANE_EN && o_link_seq == 3'h0)
		else $error("outputs wrong after reset");
endmodule
`default_nettype wire

// file: tb/serial_link_output_control_test.sv
// Bench for the controller and device joined by the register port.
// Assumes a 10 MHz clock and the controller map at 0x0, 0x4 and 0x8.
`default_nettype none
module serial_link_output_control_test
	import slo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r;} slo_row_t;
	typedef struct {logic [7:0] pol; logic inv; logic f; logic s; logic e;} slo_pin_t;
	logic i_clk = 0, i_nrst = 0, cyc = 0, stb = 0, we = 0, p1 = 0, p2 = 0, sr = 0, overrange_flag = 0;
	logic [31:0] adr = '0, dat = '0, q, wq;
	logic ack, sch, fs, su, ois, oop, lcv;
	logic [15:0] tw, w, smp = 16'h1235;
	logic [7:0] lp;
	logic [2:0] ls, gf = 3'h0;
	int n_mismatch = 0, num_checks = 0, ncyc = 0, n;
	int exp_sr[7] = '{0, 3, 0, 1, 2, 1, 1};
	slo_row_t rows[12] = '{'{ADDR_FRAMES_PER_MF, 8'h03, 8'h00}, '{ADDR_SYNC_SYSREF, 8'h04, 8'h00},
		'{ADDR_LANE_ARR, 8'h0d, 8'h00}, '{ADDR_DDC_DIV, 8'h0f, 8'h00}, '{ADDR_SER_DIV, 8'h04, 8'h00},
		'{ADDR_TRUNC_BAL, 8'h22, 8'h00}, '{ADDR_LANE_EN, 8'ha5, 8'hff}, '{ADDR_SYNC_POL, 8'h01, 8'h00},
		'{ADDR_LINK_SEQ, 8'h05, 8'h00}, '{ADDR_TPORT_PAT, 8'hf0, 8'h00},
		'{ADDR_GPIN_POL, 8'h70, 8'h00}, '{ADDR_OVR_ROUTE, 8'hf0, 8'h00}};
	slo_pin_t pins[5] = '{'{8'h00, 0, 1, 0, 1}, '{8'h00, 1, 1, 0, 0}, '{8'h20, 0, 1, 0, 0},
		'{8'h40, 0, 1, 1, 1}, '{8'h10, 0, 0, 1, 1}};
	slo_if u_slo_if();
	slo_ctrl u_slo_ctrl(.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(dat), .o_wb_dat(wq), .o_wb_ack(ack), .dev(u_slo_if));
	slo_device u_slo_device(.i_clk(i_clk), .i_nrst(i_nrst), .bus(u_slo_if), .i_first_pin(p1),
		.i_second_pin(p2), .i_sysref(sr), .i_overrange(overrange_flag), .i_sample(smp), .i_gpin_func(gf),
		.o_tx_word(tw), .o_tx_sync_char(sch), .o_lane_power(lp), .o_frame_start(fs),
		.o_sysref_used(su), .o_ovr_in_stream(ois), .o_ovr_on_pin(oop), .o_lane_code_valid(lcv),
		.o_link_seq(ls));
	slo_props u_slo_props(.i_clk(i_clk), .i_nrst(i_nrst), .wr(u_slo_if.wr), .rd(u_slo_if.rd),
		.addr(u_slo_if.addr), .wdata(u_slo_if.wdata), .rvalid(u_slo_if.rvalid), .o_tx_word(tw),
		.o_tx_sync_char(sch), .o_lane_power(lp), .o_ovr_in_stream(ois), .o_ovr_on_pin(oop),
		.o_lane_code_valid(lcv), .o_link_seq(ls));
	// ----------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------
	always #50 i_clk = ~i_clk;
	// Hang guard, far above the fewer than a thousand cycles the run needs
	always @(posedge i_clk)
	begin
		ncyc++;
		if (ncyc == 10000)
		begin
			n_mismatch++;
			close_out;
		end
	end
	task ck(input bit ok, input string m);
		num_checks++;
		if (!ok)
		begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task close_out;
		if (num_checks > 0 && n_mismatch == 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Request held until the rising edge that samples ack high; data taken at that edge
	task wb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dat <= d;
		k = 0;
		do
		begin
			@(posedge i_clk);
			k++;
		end
		while (ack !== 1'b1);
		q = wq;
		cyc <= 1'b0;
		stb <= 1'b0;
		ck(k == 2, "ack latency");
	endtask
	task poll;
		int k;
		k = 0;
		do
		begin
			wb(1'b0, WB_STAT, '0);
			k++;
		end
		while (q[1] !== 1'b0 && k < 20);
		ck(k < 20, "controller stuck busy");
	endtask
	task dw(input logic [11:0] a, input logic [7:0] d);
		wb(1'b1, WB_CMD, {4'h8, a, 8'h00, d});
		poll;
	endtask
	task dr(input logic [11:0] a);
		wb(1'b1, WB_CMD, {4'h0, a, 16'h0000});
		poll;
		wb(1'b0, WB_PINS, '0);
	endtask
	task wfs;
		n = 0;
		do
		begin
			@(negedge i_clk);
			n++;
		end
		while (fs !== 1'b1 && n < 300);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_nrst <= 1'b1;
		foreach (rows[i])
		begin
			dr(rows[i].a);
			ck(q[7:0] === rows[i].r, "reset value");
			dw(rows[i].a, rows[i].w);
			dr(rows[i].a);
			ck(q[7:0] === rows[i].w, "readback");
		end
		wb(1'b0, 32'h0000_0010, '0);
		ck(q === '0, "unmapped read");
		// Frame count field holds 3, so four cycles between starts
		wfs;
		wfs;
		ck(n == 4, "multiframe length");
		for (int i = 0; i < 8; i++)
		begin
			dw(ADDR_LINK_SEQ, 8'(i));
			ck(ls === 3'(i), "test sequence");
			dw(ADDR_LANE_ARR, 8'(i * 5));
			ck(lcv === (i > 0 && i < 3), "lane code valid");
		end
		dw(ADDR_LANE_EN, 8'h3c);
		ck(lp === 8'h3c, "lane power");
		dw(ADDR_SYNC_SYSREF, 8'h00);
		foreach (pins[i])
		begin
			dw(ADDR_GPIN_POL, pins[i].pol);
			dw(ADDR_SYNC_POL, {7'h00, pins[i].inv});
			p1 <= pins[i].f;
			p2 <= pins[i].s;
			repeat (4) @(negedge i_clk);
			ck(sch === pins[i].e, "sync from pins");
		end
		// Both pins high: the pair says no sync, the first pin alone says sync
		@(posedge i_clk);
		p1 <= 1'b1;
		gf <= 3'h1;
		repeat (4) @(negedge i_clk);
		ck(sch === 1'b1, "single pin sync");
		dw(ADDR_SYNC_SYSREF, 8'h40);
		ck(sch === 1'b0, "override off");
		p2 <= 1'b0;
		gf <= 3'h0;
		dw(ADDR_SYNC_SYSREF, 8'h60);
		ck(sch === 1'b1 && tw === 16'hbcbc, "override on");
		dw(ADDR_SYNC_SYSREF, 8'h00);
		dw(ADDR_TPORT_PAT, 8'h24);
		@(negedge i_clk);
		w = tw;
		@(negedge i_clk);
		ck(16'(tw - w) === 16'h0003, "ramp step");
		dw(ADDR_TPORT_PAT, 8'h02);
		@(negedge i_clk);
		w = tw;
		@(negedge i_clk);
		ck((w ^ tw) === 16'hffff && (tw === 16'h0000 || tw === 16'hffff), "toggle");
		overrange_flag <= 1'b1;
		dw(ADDR_OVR_ROUTE, 8'hf0);
		ck(oop === 1'b1 && ois === 1'b0, "overrange on pins");
		dw(ADDR_OVR_ROUTE, 8'h00);
		ck(ois === 1'b1 && oop === 1'b0, "overrange in stream");
		// Three pulses per policy; writing the policy clears its pulse count
		for (int m = 0; m < 7; m++)
		begin
			dw(ADDR_SYNC_SYSREF, 8'(m));
			n = 0;
			repeat (3)
			begin
				@(posedge i_clk);
				sr <= 1'b1;
				@(posedge i_clk);
				sr <= 1'b0;
				repeat (6)
				begin
					@(negedge i_clk);
					n += int'(su === 1'b1);
				end
			end
			ck(n == exp_sr[m], "sysref policy");
		end
		// Sample LSB is set, so truncation shows only with the drop bit in the 12-bit code
		dw(ADDR_TPORT_PAT, 8'h00);
		dw(ADDR_LANE_ARR, LANE_ARR_12BIT);
		dw(ADDR_TRUNC_BAL, 8'h00);
		ck(tw === 16'h1235, "no truncate without bit");
		dw(ADDR_TRUNC_BAL, 8'h20);
		ck(tw === 16'h1234, "truncate in 12-bit code");
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (2) @(negedge i_clk);
		ck(lp === 8'hff && ls === 3'h0, "mid-run reset");
		@(posedge i_clk);
		i_nrst <= 1'b1;
		dr(ADDR_LANE_EN);
		ck(q[7:0] === 8'hff, "mask after reset");
		close_out;
	end
endmodule
`default_nettype wire
